// ===== hdl/pie_enable_cell.sv
/*
 * One overflow interrupt enable bit with set-only and clear-only writes.
 * Assumes at most one of set and clear is asserted in a cycle; if both
 * come, set wins.
 */
`timescale 1ns/1ps

module pie_enable_cell
(
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    input  wire logic set_in,
    input  wire logic clr_in,
    output logic      en_out
);

    logic en_r;
    logic en_nxt;

    // set only turns on, clear only turns off
    always_comb
    begin
        en_nxt = en_r;
        if (clr_in)
        begin
            en_nxt = 1'b0;    // see (RL5)
        end
        if (set_in)
        begin
            en_nxt = 1'b1;    // see (RL2)
        end
    end

    // enable state
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            en_r <= pie_pkg::PIE_EN_RESET;
        end
        else
        begin
            en_r <= en_nxt;
        end
    end

    assign en_out = en_r;

endmodule

// ===== hdl/pie_pkg.sv
/*
 * Shared constants of the overflow interrupt enable bank: coprocessor
 * selectors, enable bit positions and the feature report layout.
 * Assumes the core presents coprocessor register accesses already
 * qualified for coprocessor 15 with opcode1 equal to zero.
 */
package pie_pkg;

    // coprocessor selector fields of the bank
    localparam logic [3:0] PIE_CRN_MON        = 4'h9;
    localparam logic [3:0] PIE_CRM_INTEN      = 4'hE;
    localparam logic [2:0] PIE_OPC2_SET       = 3'h1;
    localparam logic [2:0] PIE_OPC2_CLR       = 3'h2;
    localparam logic [3:0] PIE_CRM_FEATURE    = 4'hF;
    localparam logic [2:0] PIE_OPC2_FEATURE   = 3'h0;

    // enable bit positions in both views
    localparam int         PIE_CYC_BIT        = 31;
    localparam int         PIE_EV0_BIT        = 0;
    localparam int         PIE_EV1_BIT        = 1;
    localparam int         PIE_NUM_EVENT      = 2;

    // reset value of every enable
    localparam logic       PIE_EN_RESET       = 1'b0;
    localparam logic [31:0] PIE_DATA_ZERO     = 32'h0000_0000;

    // feature report field positions
    localparam int         PIE_FR_N_LSB       = 0;
    localparam int         PIE_FR_RAO_LSB     = 8;
    localparam int         PIE_FR_SIZE_LSB    = 11;
    localparam int         PIE_FR_CYCLE_BIT   = 14;
    localparam int         PIE_FR_PRESC_BIT   = 15;
    localparam int         PIE_FR_EXPORT_BIT  = 16;
    localparam int         PIE_FR_USER_BIT    = 19;

    // feature report field values
    localparam logic [4:0] PIE_FR_N_VAL       = 5'h02;
    localparam logic [2:0] PIE_FR_RAO_VAL     = 3'h7;
    localparam logic [1:0] PIE_FR_SIZE_VAL    = 2'h3;
    localparam logic       PIE_FR_FLAG_VAL    = 1'b1;

    // access kinds seen by the decoder
    typedef enum logic [1:0] {
        PIE_SEL_NONE,
        PIE_SEL_SET,
        PIE_SEL_CLR,
        PIE_SEL_FEATURE
    } pie_sel_t;

endpackage

// ===== hdl/pie_top.sv
/*
 * Overflow interrupt enable bank of the performance monitor: the
 * enable-set view, the enable-clear view, the feature report and the
 * monitor interrupt output.
 * Assumes a coprocessor access port synchronous to sys_clk_in, one
 * access per request pulse, and overflow flags held as levels by the
 * counter logic outside this block.
 * Security state is not an input: both views serve both states.
 * Refused and unmapped accesses are answered with an undefined pulse
 * and zero read data; the feature report is readable in any mode.
 */
// Notes on behaviour
// (RL1) reading the set view gives enables: bit 31 cycle, bits 1 and 0 events
// (RL2) a one written through the set view turns that enable on; zero leaves it
// (RL3) the set view never clears; only the clear view turns enables off
// (RL4) reading the clear view gives the same enable state, bit 31 for cycles
// (RL5) a one written through the clear view disables that enable; zero does nothing
// (RL6) clear view bits 1 and 0 clear event counter one and zero enables
// (RL7) set view bits 1 and 0 enable event counter one and zero interrupts
// (RL8) an enabled counter overflow raises the monitor interrupt output
// (RL9) both views accept privileged accesses only, shared by both security states
// (RL10) feature report low five bits show two event counters
// (RL11) feature report size field reads three, meaning 32-bit counters
// (RL12) feature report bits 15 and 14 read one: prescale and cycle counter
// (RL13) feature report bits 19 and 16 read one: user enable and event export
// (RL14) unused enable bits read zero; feature report is constant and ignores writes
`timescale 1ns/1ps

module pie_top
#(
    parameter int NUM_EVENT = pie_pkg::PIE_NUM_EVENT
)
(
    input  wire logic                 sys_clk_in,
    input  wire logic                 arst_n_in,
    input  wire logic                 cp_req_in,
    input  wire logic                 cp_write_in,
    input  wire logic                 cp_priv_in,
    input  wire logic [3:0]           cp_crn_in,
    input  wire logic [3:0]           cp_crm_in,
    input  wire logic [2:0]           cp_opc2_in,
    input  wire logic [31:0]          cp_wdata_in,
    input  wire logic                 ovf_cycle_in,
    input  wire logic [NUM_EVENT-1:0] ovf_event_in,
    output logic                      cp_ack_out,
    output logic                      cp_undef_out,
    output logic [31:0]               cp_rdata_out,
    output logic                      monitor_interrupt_out
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------

    logic rst_meta_r;
    logic rst_n_r;

    // two-stage release of the asynchronous reset; entry stays
    // asynchronous so the bank clears even with the clock stopped
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------

    pie_pkg::pie_sel_t sel;
    logic              sel_is_inten;
    logic              access_ok;
    logic              do_set;
    logic              do_clr;
    logic              sel_is_feature;
    logic              wr_ok;

    // map the coprocessor selector onto one of the three registers;
    // every other selector stays unmapped and is refused later
    always_comb
    begin
        sel = pie_pkg::PIE_SEL_NONE;
        if (cp_crn_in == pie_pkg::PIE_CRN_MON)
        begin
            if (cp_crm_in == pie_pkg::PIE_CRM_INTEN && cp_opc2_in == pie_pkg::PIE_OPC2_SET)
            begin
                sel = pie_pkg::PIE_SEL_SET;
            end
            else if (cp_crm_in == pie_pkg::PIE_CRM_INTEN && cp_opc2_in == pie_pkg::PIE_OPC2_CLR)
            begin
                sel = pie_pkg::PIE_SEL_CLR;
            end
            else if (cp_crm_in == pie_pkg::PIE_CRM_FEATURE && cp_opc2_in == pie_pkg::PIE_OPC2_FEATURE)
            begin
                sel = pie_pkg::PIE_SEL_FEATURE;
            end
        end
    end

    // privilege check; security state is not looked at, so one
    // copy of the enables serves both states
    always_comb
    begin
        sel_is_inten   = (sel == pie_pkg::PIE_SEL_SET) || (sel == pie_pkg::PIE_SEL_CLR);
        sel_is_feature = (sel == pie_pkg::PIE_SEL_FEATURE);
        access_ok      = 1'b0;
        if (sel_is_inten)
        begin
            access_ok = cp_priv_in;    // see (RL9)
        end
        else if (sel_is_feature)
        begin
            access_ok = 1'b1;          // no privilege needed here
        end
    end

    // write strobes into the enable cells; a refused write must
    // never reach a cell
    always_comb
    begin
        wr_ok  = cp_req_in && cp_write_in && access_ok;
        do_set = wr_ok && (sel == pie_pkg::PIE_SEL_SET);
        do_clr = wr_ok && (sel == pie_pkg::PIE_SEL_CLR);
    end

    // ------------------------------------------------------------
    // enable cells: entries 0..NUM_EVENT-1 are events, last is cycles
    // ------------------------------------------------------------

    logic [NUM_EVENT:0] en;
    logic [NUM_EVENT:0] ovf;
    logic [NUM_EVENT:0] hit;
    logic [31:0]        en_word;

    genvar gi;
    generate
        for (gi = 0; gi <= NUM_EVENT; gi = gi + 1)
        begin : g_en
            localparam int BIT = (gi == NUM_EVENT) ? pie_pkg::PIE_CYC_BIT : gi;
            logic cell_set;
            logic cell_clr;

            // a one in the bit's own position acts; zeros leave it,
            // and the set strobe has no path to turning a cell off
            assign cell_set = do_set && cp_wdata_in[BIT];    // see (RL2) (RL7)
            assign cell_clr = do_clr && cp_wdata_in[BIT];    // see (RL3) (RL5) (RL6)

            pie_enable_cell u_cell
            (
                .sys_clk_in (sys_clk_in),
                .rst_n_in   (rst_n_r),
                .set_in     (cell_set),
                .clr_in     (cell_clr),
                .en_out     (en[gi])
            );

            // route this entry's overflow flag; the last entry is the cycle counter
            if (gi == NUM_EVENT)
            begin : g_cyc
                assign ovf[gi] = ovf_cycle_in;
            end
            else
            begin : g_evt
                assign ovf[gi] = ovf_event_in[gi];
            end

            // this entry asks for the interrupt
            assign hit[gi] = en[gi] && ovf[gi];    // see (RL8)
        end
    endgenerate

    // enable state as seen through either view; the unused
    // middle bits stay zero whatever was written
    always_comb
    begin
        en_word = pie_pkg::PIE_DATA_ZERO;                         // see (RL14)
        for (int i = 0; i < NUM_EVENT; i++)
        begin
            en_word[i] = en[i];                                   // see (RL1) (RL4)
        end
        en_word[pie_pkg::PIE_CYC_BIT] = en[NUM_EVENT];            // see (RL1) (RL4)
    end

    // ------------------------------------------------------------
    // feature report, a constant word
    // ------------------------------------------------------------

    logic [31:0] feature_word;

    // build the report from its fields; reserved bits fixed
    // nothing can write it, so a write is simply acknowledged
    always_comb
    begin
        feature_word = pie_pkg::PIE_DATA_ZERO;
        feature_word[pie_pkg::PIE_FR_N_LSB +: 5]    = pie_pkg::PIE_FR_N_VAL;      // see (RL10)
        feature_word[pie_pkg::PIE_FR_RAO_LSB +: 3]  = pie_pkg::PIE_FR_RAO_VAL;    // see (RL14)
        feature_word[pie_pkg::PIE_FR_SIZE_LSB +: 2] = pie_pkg::PIE_FR_SIZE_VAL;   // see (RL11)
        feature_word[pie_pkg::PIE_FR_CYCLE_BIT]     = pie_pkg::PIE_FR_FLAG_VAL;   // see (RL12)
        feature_word[pie_pkg::PIE_FR_PRESC_BIT]     = pie_pkg::PIE_FR_FLAG_VAL;   // see (RL12)
        feature_word[pie_pkg::PIE_FR_EXPORT_BIT]    = pie_pkg::PIE_FR_FLAG_VAL;   // see (RL13)
        feature_word[pie_pkg::PIE_FR_USER_BIT]      = pie_pkg::PIE_FR_FLAG_VAL;   // see (RL13)
    end

    // ------------------------------------------------------------
    // access answer
    // ------------------------------------------------------------

    logic        ack_r;
    logic        ack_nxt;
    logic        undef_r;
    logic        undef_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] read_word;

    // word that a read of the selected register would return
    always_comb
    begin
        unique case (sel)
            pie_pkg::PIE_SEL_SET:     read_word = en_word;         // see (RL1)
            pie_pkg::PIE_SEL_CLR:     read_word = en_word;         // see (RL4)
            pie_pkg::PIE_SEL_FEATURE: read_word = feature_word;
            pie_pkg::PIE_SEL_NONE:    read_word = pie_pkg::PIE_DATA_ZERO;
        endcase
    end

    // answer every request one cycle later; refused ones read zero
    // so nothing leaks to a mode that may not look
    always_comb
    begin
        ack_nxt   = 1'b0;
        undef_nxt = 1'b0;
        rdata_nxt = pie_pkg::PIE_DATA_ZERO;
        if (cp_req_in)
        begin
            ack_nxt = 1'b1;
            if (!access_ok)
            begin
                undef_nxt = 1'b1;    // see (RL9)
            end
            else if (!cp_write_in)
            begin
                rdata_nxt = read_word;
            end
        end
    end

    // answer registers
    always_ff @(posedge sys_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            ack_r   <= 1'b0;
            undef_r <= 1'b0;
            rdata_r <= pie_pkg::PIE_DATA_ZERO;
        end
        else
        begin
            ack_r   <= ack_nxt;
            undef_r <= undef_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // monitor interrupt
    // ------------------------------------------------------------

    logic irq_r;
    logic irq_nxt;

    // any entry whose enable and overflow are both on raises the
    // request; it is a level and drops one clock after either goes
    always_comb
    begin
        irq_nxt = |hit;    // see (RL8)
    end

    // interrupt register
    always_ff @(posedge sys_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------

    assign cp_ack_out            = ack_r;
    assign cp_undef_out          = undef_r;
    assign cp_rdata_out          = rdata_r;
    assign monitor_interrupt_out = irq_r;

endmodule

// ===== tb/pie_top_assertions.sv
/* port-level checks of the overflow interrupt enable bank.
 * assumes binding into every pie_top, one clock, reset arst_n_in. */
`timescale 1ns/1ps

module pie_top_assertions
#(
    parameter int NUM_EVENT = 2
)
(
    input  wire logic                 sys_clk_in,
    input  wire logic                 arst_n_in,
    input  wire logic                 cp_req_in,
    input  wire logic                 cp_write_in,
    input  wire logic                 cp_priv_in,
    input  wire logic [3:0]           cp_crn_in,
    input  wire logic [3:0]           cp_crm_in,
    input  wire logic [2:0]           cp_opc2_in,
    input  wire logic [31:0]          cp_wdata_in,
    input  wire logic                 ovf_cycle_in,
    input  wire logic [NUM_EVENT-1:0] ovf_event_in,
    input  wire logic                 cp_ack_out,
    input  wire logic                 cp_undef_out,
    input  wire logic [31:0]          cp_rdata_out,
    input  wire logic                 monitor_interrupt_out
);
    // decoded request kinds
    logic req_en;
    logic req_set;
    logic req_clr;
    logic req_feat;
    assign req_en   = cp_req_in && cp_crn_in == pie_pkg::PIE_CRN_MON && cp_crm_in == pie_pkg::PIE_CRM_INTEN
                      && (cp_opc2_in == pie_pkg::PIE_OPC2_SET || cp_opc2_in == pie_pkg::PIE_OPC2_CLR);
    assign req_set  = req_en && cp_write_in && cp_priv_in && cp_opc2_in == pie_pkg::PIE_OPC2_SET;
    assign req_clr  = req_en && cp_write_in && cp_priv_in && cp_opc2_in == pie_pkg::PIE_OPC2_CLR;
    assign req_feat = cp_req_in && cp_crn_in == pie_pkg::PIE_CRN_MON && cp_crm_in == pie_pkg::PIE_CRM_FEATURE
                      && cp_opc2_in == pie_pkg::PIE_OPC2_FEATURE;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    // answer timing
    AST_ACK: assert property (cp_req_in |=> cp_ack_out)
        else $error("no ack after request");
    AST_IDLE: assert property (!$past(cp_req_in)
        |-> !cp_ack_out && !cp_undef_out && cp_rdata_out == 32'h0)
        else $error("ack or data without request");
    // register contents and refused accesses
    AST_RSV: assert property (req_en && !cp_write_in && cp_priv_in |=> cp_rdata_out[30:2] == 29'h0)
        else $error("reserved enable bits not zero");
    AST_FEAT: assert property (req_feat && !cp_write_in
        |=> cp_rdata_out == 32'h0009_DF02 && !cp_undef_out)
        else $error("feature report value wrong");
    AST_PRIV: assert property (req_en && !cp_priv_in |=> cp_undef_out && cp_rdata_out == 32'h0)
        else $error("unprivileged access not refused");
    AST_UNMAP: assert property (cp_req_in && cp_crn_in != pie_pkg::PIE_CRN_MON
        |=> cp_ack_out && cp_undef_out)
        else $error("unmapped access not refused");
    // interrupt relations
    AST_IRQ_CAUSE: assert property (monitor_interrupt_out
        |-> $past(ovf_cycle_in) || ($past(ovf_event_in) != '0))
        else $error("interrupt without overflow");
    AST_CLR_ALL: assert property (req_clr && cp_wdata_in[31] && cp_wdata_in[1:0] == 2'h3
        |-> ##2 !monitor_interrupt_out)
        else $error("interrupt after clearing all enables");
    AST_SET_IRQ: assert property (req_set && cp_wdata_in[31] ##1 ovf_cycle_in
        |=> monitor_interrupt_out)
        else $error("enabled cycle overflow gave no interrupt");

    // main scenarios seen
    COV_SET: cover property (req_set);
    COV_CLR: cover property (req_clr);
    COV_FEAT: cover property (req_feat && !cp_write_in);
    COV_IRQ: cover property (monitor_interrupt_out);
endmodule

bind pie_top pie_top_assertions #(.NUM_EVENT(NUM_EVENT)) u_chk (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .cp_req_in(cp_req_in), .cp_write_in(cp_write_in),
    .cp_priv_in(cp_priv_in), .cp_crn_in(cp_crn_in), .cp_crm_in(cp_crm_in), .cp_opc2_in(cp_opc2_in),
    .cp_wdata_in(cp_wdata_in), .ovf_cycle_in(ovf_cycle_in), .ovf_event_in(ovf_event_in),
    .cp_ack_out(cp_ack_out), .cp_undef_out(cp_undef_out), .cp_rdata_out(cp_rdata_out),
    .monitor_interrupt_out(monitor_interrupt_out));

// ===== tb/pie_top_tb.sv
/* self-checking bench of pie_top: enable views, feature report, interrupt.
 * assumes pie_pkg, the design and its checker are compiled first. */
`timescale 1ns/1ps

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module pie_top_tb;
    logic        sys_clk_in;
    logic        arst_n_in;
    logic        cp_req_in;
    logic        cp_write_in;
    logic        cp_priv_in;
    logic [3:0]  cp_crn_in;
    logic [3:0]  cp_crm_in;
    logic [2:0]  cp_opc2_in;
    logic [31:0] cp_wdata_in;
    logic        ovf_cycle_in;
    logic [1:0]  ovf_event_in;
    logic        cp_ack_out;
    logic        cp_undef_out;
    logic [31:0] cp_rdata_out;
    logic        monitor_interrupt_out;
    int          n_fail;
    int          compares;
    int          cycles;
    logic [2:0]  fl [3];
    logic [31:0] em [3];

    pie_top #(.NUM_EVENT(2)) uut (
        .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .cp_req_in(cp_req_in), .cp_write_in(cp_write_in),
        .cp_priv_in(cp_priv_in), .cp_crn_in(cp_crn_in), .cp_crm_in(cp_crm_in), .cp_opc2_in(cp_opc2_in),
        .cp_wdata_in(cp_wdata_in), .ovf_cycle_in(ovf_cycle_in), .ovf_event_in(ovf_event_in),
        .cp_ack_out(cp_ack_out), .cp_undef_out(cp_undef_out), .cp_rdata_out(cp_rdata_out),
        .monitor_interrupt_out(monitor_interrupt_out));

    // 250 MHz clock
    initial
    begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    // hang guard
    always @(posedge sys_clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    // one access: request held one edge, answer checked the cycle after
    task automatic acc(input logic w, input logic p, input logic [3:0] crn, input logic [3:0] crm,
                       input logic [2:0] op, input logic [31:0] wd, input logic un, input logic [31:0] rd);
        cp_req_in   = 1'b1;
        cp_write_in = w;
        cp_priv_in  = p;
        cp_crn_in   = crn;
        cp_crm_in   = crm;
        cp_opc2_in  = op;
        cp_wdata_in = wd;
        cyc(1);
        cp_req_in = 1'b0;
        `CHK("ack", 1'b1, cp_ack_out)
        `CHK("undef", un, cp_undef_out)
        `CHK("rdata", rd, cp_rdata_out)
        cyc(1);
        `CHK("rdata_idle", 32'h0, cp_rdata_out)
    endtask

    task automatic set_w(input logic [31:0] v);
        acc(1'b1, 1'b1, 4'h9, 4'hE, 3'h1, v, 1'b0, 32'h0);
    endtask

    task automatic clr_w(input logic [31:0] v);
        acc(1'b1, 1'b1, 4'h9, 4'hE, 3'h2, v, 1'b0, 32'h0);
    endtask

    // both views read the same enable word
    task automatic chk_en(input logic [31:0] v);
        acc(1'b0, 1'b1, 4'h9, 4'hE, 3'h1, 32'h0, 1'b0, v);
        acc(1'b0, 1'b1, 4'h9, 4'hE, 3'h2, 32'h0, 1'b0, v);
    endtask

    // main sequence
    initial
    begin
        {arst_n_in, cp_req_in, cp_write_in, cp_priv_in, ovf_cycle_in, ovf_event_in} = '0;
        {cp_crn_in, cp_crm_in, cp_opc2_in, cp_wdata_in} = '0;
        fl = '{3'h4, 3'h2, 3'h1};
        em = '{32'h8000_0000, 32'h0000_0002, 32'h0000_0001};
        cyc(4);
        arst_n_in = 1'b1;
        cyc(4);
        `CHK("irq_reset", 1'b0, monitor_interrupt_out)
        chk_en(32'h0);
        acc(1'b0, 1'b0, 4'h9, 4'hF, 3'h0, 32'h0, 1'b0, 32'h0009_DF02);
        acc(1'b1, 1'b1, 4'h9, 4'hF, 3'h0, 32'hFFFF_FFFF, 1'b0, 32'h0);
        acc(1'b0, 1'b1, 4'h9, 4'hF, 3'h0, 32'h0, 1'b0, 32'h0009_DF02);
        set_w(32'h8000_0001);
        chk_en(32'h8000_0001);
        set_w(32'h7FFF_FFFE);
        chk_en(32'h8000_0003);
        clr_w(32'h0);
        chk_en(32'h8000_0003);
        clr_w(32'h1);
        chk_en(32'h8000_0002);
        clr_w(32'h8000_0000);
        chk_en(32'h0000_0002);
        acc(1'b1, 1'b0, 4'h9, 4'hE, 3'h1, 32'hFFFF_FFFF, 1'b1, 32'h0);
        acc(1'b0, 1'b0, 4'h9, 4'hE, 3'h2, 32'h0, 1'b1, 32'h0);
        chk_en(32'h0000_0002);
        clr_w(32'hFFFF_FFFF);
        chk_en(32'h0);
        acc(1'b0, 1'b1, 4'hA, 4'hE, 3'h1, 32'h0, 1'b1, 32'h0);
        // each counter: overflow alone, then enabled, dropped, cleared
        for (int k = 0; k < 3; k++)
        begin
            {ovf_cycle_in, ovf_event_in} = fl[k];
            cyc(2);
            `CHK("irq_disabled", 1'b0, monitor_interrupt_out)
            set_w(em[k]);
            `CHK("irq_enabled", 1'b1, monitor_interrupt_out)
            {ovf_cycle_in, ovf_event_in} = 3'h0;
            cyc(1);
            `CHK("irq_flag_low", 1'b0, monitor_interrupt_out)
            {ovf_cycle_in, ovf_event_in} = fl[k];
            cyc(1);
            `CHK("irq_again", 1'b1, monitor_interrupt_out)
            clr_w(em[k]);
            `CHK("irq_cleared", 1'b0, monitor_interrupt_out)
            {ovf_cycle_in, ovf_event_in} = 3'h0;
        end
        finish_test();
    end
endmodule
